// ### rtl/wa_store.sv
// Waveform digitizer control, waveform memory, repair pass and overflow handling
`timescale 1ns/1ps
`default_nettype none
module wa_store (
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic              ce_in,
    input  wire logic              start_in,
    input  wire logic [1:0]        mode_in,
    input  wire logic              stop_in,
    input  wire logic              sweep_end_in,
    input  wire logic [0:0]        acq_slot_in,
    input  wire logic              smp_valid_in,
    input  wire wa_pkg::wa_smp_t   smp_in,
    output logic                   smp_ready_out,
    input  wire logic              rt_tick_in,
    input  wire logic [15:0]       rt_v_in,
    input  wire logic [15:0]       scale_in,
    input  wire logic              calc_valid_in,
    input  wire wa_pkg::wa_calc_t  calc_in,
    input  wire logic              calc_last_in,
    output logic                   calc_ready_out,
    input  wire wa_pkg::wa_const_t const_in,
    output wa_pkg::wa_const_t      const_out,
    output logic                   const_stars_out,
    output logic                   const_zero_out,
    input  wire logic [0:0]        rd_slot_in,
    input  wire logic [8:0]        rd_idx_in,
    output logic [15:0]            rd_data_out,
    output logic [15:0]            rd_disp_out,
    input  wire logic              xy_mode_in,
    input  wire logic [0:0]        xy_hslot_in,
    input  wire logic [15:0]       tb_scale_in,
    input  wire logic signed [15:0] cursor_div_in,
    output logic [15:0]            horizontal_scale_factor_out,
    output logic signed [31:0]     horizontal_cursor_reading_out,
    output logic                   busy_out,
    output logic                   done_out,
    output logic [8:0]             rt_base_out
);
    localparam int P  = wa_pkg::PPW;
    localparam int IW = wa_pkg::IDX_W;
    localparam int AW = wa_pkg::SLOT_W + wa_pkg::IDX_W;
    localparam logic [IW-1:0] LAST = IW'(P - 1);

    function automatic logic [15:0] avg2(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        return s[16:1];
    endfunction

    wa_pkg::wa_state_t st_q, st_d;
    logic [1:0]        mode_q, mode_d;
    logic [0:0]        slot_q, slot_d;
    logic [P-1:0]      vld_q, vld_d;
    logic [IW:0]       fill_q, fill_d, rtn_q, rtn_d;
    logic [IW-1:0]     i_q, i_d, last_q, last_d, rtp_q, rtp_d;
    logic [15:0]       lv_q, lv_d;
    logic              hitl_q, hitl_d, hitr_q, hitr_d, swept_q, swept_d, tiny_q, tiny_d, done_q, done_d;
    logic [15:0]       scale_q [wa_pkg::SLOTS];
    logic [15:0]       mem [wa_pkg::SLOTS * P];
    logic              we;
    logic [AW-1:0]     waddr;
    logic [15:0]       wdata;

    // Two-entry sample buffer: repair and memory stalls never drop a sample
    wa_pkg::wa_smp_t   fb_q [2];
    wa_pkg::wa_smp_t   fb_d [2];
    wa_pkg::wa_smp_t   head;
    logic              fwp_q, fwp_d, frp_q, frp_d, push, pop;
    logic [1:0]        fcnt_q, fcnt_d;
    logic              left, right, et_done;
    logic [IW-1:0]     sidx;
    logic [15:0]       cur, nxt, calc_v;

    assign smp_ready_out  = fcnt_q != wa_pkg::FIFO_FULL;
    assign calc_ready_out = st_q == wa_pkg::ST_IDLE && !start_in;
    assign push  = smp_valid_in && smp_ready_out;
    assign pop   = fcnt_q != 2'h0 && st_q == wa_pkg::ST_ACQ && mode_q != wa_pkg::MODE_RT;
    assign head  = fb_q[frp_q];
    assign left  = head.h < 0;
    assign right = head.h >= 16'sh0200;
    assign sidx  = left ? '0 : (right ? LAST : head.h[IW-1:0]);
    assign cur   = mem[{slot_q, i_q}];
    assign nxt   = mem[{slot_q, IW'(i_q + 1'b1)}];
    assign et_done = swept_q && 32'(fill_q) * 32'(wa_pkg::FULL_PCT) >= 32'(P) * 32'(wa_pkg::FILL_PCT);
    assign calc_v = calc_in.tiny ? 16'h0000 :
                    calc_in.val > wa_pkg::CALC_MAX ? wa_pkg::PT_SAT_P :
                    calc_in.val < wa_pkg::CALC_MIN ? wa_pkg::PT_SAT_N : calc_in.val[15:0];

    always_comb begin
        fb_d   = fb_q;
        fwp_d  = fwp_q;
        frp_d  = frp_q;
        fcnt_d = fcnt_q;
        if (push) begin
            fb_d[fwp_q] = smp_in;
            fwp_d = ~fwp_q;
        end
        if (pop) begin
            frp_d = ~frp_q;
        end
        fcnt_d = 2'(fcnt_q + {1'b0, push} - {1'b0, pop});
    end

    always_comb begin
        st_d = st_q; mode_d = mode_q; slot_d = slot_q; vld_d = vld_q; fill_d = fill_q;
        i_d = i_q; last_d = last_q; rtp_d = rtp_q; rtn_d = rtn_q; lv_d = lv_q;
        hitl_d = hitl_q; hitr_d = hitr_q; swept_d = swept_q; tiny_d = tiny_q; done_d = 1'b0;
        we = 1'b0; waddr = '0; wdata = '0;
        case (st_q)
            wa_pkg::ST_IDLE: begin
                if (start_in) begin
                    st_d = wa_pkg::ST_ACQ; mode_d = mode_in; slot_d = acq_slot_in;
                    vld_d = '0; fill_d = '0; last_d = '0; rtp_d = '0; rtn_d = '0;
                    hitl_d = 1'b0; hitr_d = 1'b0; swept_d = 1'b0;
                end else if (calc_valid_in) begin
                    we = 1'b1;
                    waddr = {1'b0, calc_in.idx};
                    wdata = calc_v;
                    tiny_d = tiny_q & calc_in.tiny;
                    if (calc_last_in) begin
                        tiny_d = 1'b1;
                        if (tiny_q & calc_in.tiny) begin
                            st_d = wa_pkg::ST_ZERO; slot_d = 1'b0; i_d = '0;
                        end
                    end
                end
            end
            wa_pkg::ST_ACQ: begin
                if (sweep_end_in) swept_d = 1'b1;
                if (mode_q == wa_pkg::MODE_RT) begin
                    if (rt_tick_in) begin
                        we = 1'b1; waddr = {slot_q, rtp_q}; wdata = rt_v_in;
                        vld_d[rtp_q] = 1'b1;
                        rtp_d = (rtp_q == LAST) ? '0 : IW'(rtp_q + 1'b1);
                        if (rtn_q != (IW+1)'(P)) rtn_d = (IW+1)'(rtn_q + 1'b1);
                        if (!vld_q[rtp_q]) fill_d = (IW+1)'(fill_q + 1'b1);
                        if (rtp_q > last_q) last_d = rtp_q;
                    end
                end else if (pop && head.gate) begin
                    we = 1'b1; waddr = {slot_q, sidx};
                    wdata = (mode_q == wa_pkg::MODE_AVG && vld_q[sidx]) ? avg2(mem[waddr], head.v) : head.v;
                    vld_d[sidx] = 1'b1;
                    if (!vld_q[sidx]) fill_d = (IW+1)'(fill_q + 1'b1);
                    if (sidx > last_q) last_d = sidx;
                    if (left) hitl_d = 1'b1;
                    if (right) hitr_d = 1'b1;
                end
                if (stop_in || (mode_q != wa_pkg::MODE_RT && et_done)) begin
                    st_d = wa_pkg::ST_FIX; i_d = '0; lv_d = '0;
                end
            end
            wa_pkg::ST_FIX: begin
                we = 1'b1; waddr = {slot_q, i_q}; wdata = cur;
                if (fill_q == '0) begin
                    wdata = 16'h0000;
                end else if (i_q == '0 && hitl_q) begin
                    wdata = nxt;
                end else if (i_q == LAST && hitr_q) begin
                    wdata = lv_q;
                end else if (!vld_q[i_q]) begin
                    if (i_q > last_q) wdata = lv_q;
                    else if (vld_q[IW'(i_q + 1'b1)]) wdata = (i_q == '0) ? nxt : avg2(lv_q, nxt);
                    else wdata = lv_q;
                end
                lv_d = wdata;
                i_d = IW'(i_q + 1'b1);
                if (i_q == LAST) st_d = wa_pkg::ST_END;
            end
            wa_pkg::ST_ZERO: begin
                we = 1'b1; waddr = {slot_q, i_q}; wdata = 16'h0000;
                i_d = IW'(i_q + 1'b1);
                if (i_q == LAST) st_d = wa_pkg::ST_END;
            end
            wa_pkg::ST_END: begin
                done_d = 1'b1;
                st_d = wa_pkg::ST_IDLE;
            end
            default: st_d = wa_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= wa_pkg::ST_IDLE; mode_q <= 2'h0; slot_q <= 1'b0; vld_q <= '0;
            fill_q <= '0; i_q <= '0; last_q <= '0; rtp_q <= '0; rtn_q <= '0; lv_q <= 16'h0000;
            hitl_q <= 1'b0; hitr_q <= 1'b0; swept_q <= 1'b0; tiny_q <= 1'b1; done_q <= 1'b0;
            fwp_q <= 1'b0; frp_q <= 1'b0; fcnt_q <= 2'h0;
            fb_q[0] <= '0; fb_q[1] <= '0;
        end else if (ce_in) begin
            st_q <= st_d; mode_q <= mode_d; slot_q <= slot_d; vld_q <= vld_d;
            fill_q <= fill_d; i_q <= i_d; last_q <= last_d; rtp_q <= rtp_d; rtn_q <= rtn_d; lv_q <= lv_d;
            hitl_q <= hitl_d; hitr_q <= hitr_d; swept_q <= swept_d; tiny_q <= tiny_d; done_q <= done_d;
            fwp_q <= fwp_d; frp_q <= frp_d; fcnt_q <= fcnt_d;
            fb_q <= fb_d;
        end
    end

    // Waveform memory is not reset; unfilled points are tracked by the valid flags
    always_ff @(posedge mclk_in) begin
        if (ce_in && we) mem[waddr] <= wdata;
    end

    // Scale factors are captured at every start, even when the trace ends empty
    wa_pkg::wa_const_t cst_d;
    logic stars_d, czero_d;
    logic [15:0] rd_d, disp_d, horizontal_scale_factor_d;
    always_comb begin
        cst_d = const_in;
        stars_d = const_in.ex > wa_pkg::DEXP_MAX;
        czero_d = const_in.ex < wa_pkg::DEXP_MIN;
        if (const_in.ex > wa_pkg::EXP_MAX) begin
            cst_d.ex = wa_pkg::EXP_MAX; cst_d.man = 16'hFFFF;
        end else if (const_in.ex < wa_pkg::EXP_MIN) begin
            cst_d = '0;
        end
        rd_d = mem[{rd_slot_in, rd_idx_in}];
        disp_d = rd_d == wa_pkg::PT_SAT_P ? wa_pkg::DISP_P3 :
                 rd_d == wa_pkg::PT_SAT_N ? wa_pkg::DISP_N3 : rd_d;
        horizontal_scale_factor_d = xy_mode_in ? scale_q[xy_hslot_in] : tb_scale_in;
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            const_out <= '0; const_stars_out <= 1'b0; const_zero_out <= 1'b0;
            rd_data_out <= 16'h0000; rd_disp_out <= 16'h0000;
            horizontal_scale_factor_out <= 16'h0000; horizontal_cursor_reading_out <= '0;
            scale_q[0] <= 16'h0000; scale_q[1] <= 16'h0000;
        end else if (ce_in) begin
            const_out <= cst_d; const_stars_out <= stars_d; const_zero_out <= czero_d;
            rd_data_out <= rd_d; rd_disp_out <= disp_d;
            horizontal_scale_factor_out <= horizontal_scale_factor_d;
            horizontal_cursor_reading_out <= cursor_div_in * $signed(horizontal_scale_factor_d);
            if (st_q == wa_pkg::ST_IDLE && start_in) scale_q[acq_slot_in] <= scale_in;
        end
    end

    assign busy_out    = st_q != wa_pkg::ST_IDLE;
    assign done_out    = done_q;
    assign rt_base_out = (rtn_q == (IW+1)'(P)) ? rtp_q : '0;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_stop; st_q == wa_pkg::ST_ACQ && stop_in && ce_in; endsequence
    sequence s_fix_run; st_q == wa_pkg::ST_FIX; endsequence
    property p_stop; s_stop |=> s_fix_run; endproperty
    a_stop: assert property (p_stop) else $error("stop did not end acquisition");
    property p_gate; pop && !head.gate |-> !we; endproperty
    a_gate: assert property (p_gate) else $error("gated-off sample written");
    property p_left; pop && head.gate && left |-> we && waddr[IW-1:0] == '0; endproperty
    a_left: assert property (p_left) else $error("left clamp missed point zero");
    property p_right; pop && head.gate && right |-> we && waddr[IW-1:0] == LAST; endproperty
    a_right: assert property (p_right) else $error("right clamp missed last point");
    property p_rt; st_q == wa_pkg::ST_ACQ && mode_q == wa_pkg::MODE_RT && rt_tick_in && ce_in
        |=> rtp_q == IW'($past(rtp_q) + 1'b1); endproperty
    a_rt: assert property (p_rt) else $error("real time pointer did not advance");
    property p_csat; ce_in && const_in.ex > wa_pkg::EXP_MAX
        |=> const_out.ex == wa_pkg::EXP_MAX && const_out.sgn == $past(const_in.sgn); endproperty
    a_csat: assert property (p_csat) else $error("constant not saturated");
    property p_cflush; ce_in && const_in.ex < wa_pkg::EXP_MIN |=> const_out == '0; endproperty
    a_cflush: assert property (p_cflush) else $error("constant not flushed");
    property p_calc; st_q == wa_pkg::ST_IDLE && !start_in && calc_valid_in
        |-> we && waddr[AW-1] == 1'b0
            && (!calc_in.tiny && calc_in.val > wa_pkg::CALC_MAX -> wdata == wa_pkg::PT_SAT_P); endproperty
    a_calc: assert property (p_calc) else $error("computed point misplaced or unsaturated");
    property p_empty; st_q == wa_pkg::ST_FIX && fill_q == '0 |-> we && wdata == 16'h0000; endproperty
    a_empty: assert property (p_empty) else $error("empty acquisition not zeroed");
    property p_end; st_q == wa_pkg::ST_FIX && i_q == LAST && ce_in |=> ##1 done_out; endproperty
    a_end: assert property (p_end) else $error("done pulse missing after repair");
    property p_fill; pop && head.gate && ce_in |=> vld_q[$past(sidx)]; endproperty
    a_fill: assert property (p_fill) else $error("accepted point not marked filled");
    property p_zero; st_q == wa_pkg::ST_ZERO |-> we && waddr[AW-1] == 1'b0 && wdata == 16'h0000; endproperty
    a_zero: assert property (p_zero) else $error("tiny waveform not cleared");
    // Points past the highest filled index can only hold the end value, never interpolate
    property p_trail; st_q == wa_pkg::ST_FIX && fill_q != '0 && i_q > last_q && i_q != LAST
        |-> we && wdata == lv_q; endproperty
    a_trail: assert property (p_trail) else $error("trailing point not copied from end point");
endmodule
`default_nettype wire

// ### rtl/wa_pkg.sv
// Shared constants, enumerations and carrier structs for the waveform acquisition store
`default_nettype none
package wa_pkg;
    localparam int          PPW       = 512;
    localparam int          IDX_W     = 9;
    localparam int          SLOTS     = 2;
    localparam int          SLOT_W    = 1;
    localparam int          PT_W      = 16;
    localparam int          FILL_PCT  = 99;
    localparam int          FULL_PCT  = 100;
    localparam int          EXP_W     = 13;
    localparam logic [1:0]  FIFO_FULL = 2'h2;
    localparam logic [15:0] PT_SAT_P  = 16'h7FFF;
    localparam logic [15:0] PT_SAT_N  = 16'h8001;
    localparam logic [15:0] DISP_P3   = 16'h1332;
    localparam logic [15:0] DISP_N3   = 16'hECCE;
    localparam logic signed [EXP_W-1:0] EXP_MAX  = 13'sh03FF;
    localparam logic signed [EXP_W-1:0] EXP_MIN  = -13'sh03E5;
    localparam logic signed [EXP_W-1:0] DEXP_MAX = 13'sh0149;
    localparam logic signed [EXP_W-1:0] DEXP_MIN = -13'sh0149;
    localparam logic signed [31:0] CALC_MAX = 32'sh00007FFF;
    localparam logic signed [31:0] CALC_MIN = -32'sh00007FFF;

    typedef enum logic [1:0] {
        MODE_RT  = 2'h0,
        MODE_ET  = 2'h1,
        MODE_AVG = 2'h2
    } wa_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ACQ  = 5'h02,
        ST_FIX  = 5'h04,
        ST_ZERO = 5'h08,
        ST_END  = 5'h10
    } wa_state_t;

    typedef struct packed {
        logic              gate;
        logic signed [15:0] h;
        logic [15:0]        v;
    } wa_smp_t;

    typedef struct packed {
        logic [IDX_W-1:0]   idx;
        logic signed [31:0] val;
        logic               tiny;
    } wa_calc_t;

    typedef struct packed {
        logic                     sgn;
        logic signed [EXP_W-1:0]  ex;
        logic [15:0]              man;
    } wa_const_t;
endpackage
`default_nettype wire

// ### bench/wa_front.sv
// Behavioural trace front end: sample pairs, sweep end and real-time ticks
`timescale 1ns/1ps
`default_nettype none
module wa_front (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output wa_pkg::wa_smp_t smp_out,
    output logic            sweep_out,
    output logic            tick_out,
    output logic [15:0]     tick_v_out
);
    initial begin
        valid_out = 1'b0;
        smp_out = '0;
        sweep_out = 1'b0;
        tick_out = 1'b0;
        tick_v_out = 16'h0000;
    end
    // Pair held until taken; released lines show garbage, not the old pair
    task automatic send(input logic g, input logic signed [15:0] h, input logic [15:0] v);
        @(negedge clk_in);
        valid_out = 1'b1;
        smp_out = '{gate: g, h: h, v: v};
        @(posedge clk_in);
        while (ready_in !== 1'b1) @(posedge clk_in);
        @(negedge clk_in);
        valid_out = 1'b0;
        smp_out = ~smp_out;
    endtask
    task automatic sweep();
        @(negedge clk_in);
        sweep_out = 1'b1;
        @(negedge clk_in);
        sweep_out = 1'b0;
    endtask
    // Ticks stand for a time-base sample clock
    task automatic tick(input logic [15:0] v);
        @(negedge clk_in);
        tick_out = 1'b1;
        tick_v_out = v;
        @(negedge clk_in);
        tick_out = 1'b0;
        tick_v_out = ~v;
    endtask
endmodule
`default_nettype wire

// ### bench/waveform_acquisition_store_tb.sv
// Self-checking bench for the waveform acquisition store
`timescale 1ns/1ps
`default_nettype none
module waveform_acquisition_store_tb;
    logic               mclk = 1'b0;
    logic               nrst = 1'b0;
    logic               start, stop, xy, cv, cl, rd_req, rd_seen;
    logic [1:0]         mode;
    logic [0:0]         slot, rs, hs;
    logic [8:0]         ri, rt_base;
    logic [15:0]        scale, rdd, rdp, hsf;
    logic signed [15:0] cur;
    logic signed [31:0] hcr;
    logic               sv, sr, swp, tk, cr, stars, zero, busy, done;
    logic [15:0]        tv;
    wa_pkg::wa_smp_t    smp;
    wa_pkg::wa_calc_t   cd;
    wa_pkg::wa_const_t  ci, co;
    logic [15:0]        ev [512];
    logic [15:0]        exp_q [$];
    int                 fail_count = 0;
    int                 total_checks = 0;
    int                 i;
    always #2 mclk = ~mclk;
    wa_front wa_front_inst (.clk_in(mclk), .ready_in(sr), .valid_out(sv), .smp_out(smp),
        .sweep_out(swp), .tick_out(tk), .tick_v_out(tv));
    wa_store wa_store_inst (.mclk_in(mclk), .nrst_in(nrst), .ce_in(1'b1), .start_in(start),
        .mode_in(mode), .stop_in(stop), .sweep_end_in(swp), .acq_slot_in(slot),
        .smp_valid_in(sv), .smp_in(smp), .smp_ready_out(sr), .rt_tick_in(tk), .rt_v_in(tv),
        .scale_in(scale), .calc_valid_in(cv), .calc_in(cd), .calc_last_in(cl),
        .calc_ready_out(cr), .const_in(ci), .const_out(co), .const_stars_out(stars),
        .const_zero_out(zero), .rd_slot_in(rs), .rd_idx_in(ri), .rd_data_out(rdd),
        .rd_disp_out(rdp), .xy_mode_in(xy), .xy_hslot_in(hs), .tb_scale_in(16'h0004),
        .cursor_div_in(cur), .horizontal_scale_factor_out(hsf),
        .horizontal_cursor_reading_out(hcr), .busy_out(busy), .done_out(done), .rt_base_out(rt_base));
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        total_checks++;
        if (seen !== e) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, e);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Read results land one cycle later and are matched against the oldest note
    always @(posedge mclk) rd_seen <= rd_req;
    always @(negedge mclk) if (rd_seen) check(rdd, exp_q.pop_front());
    task automatic rd(input logic s, input int k, input logic [15:0] e);
        @(negedge mclk);
        rs = s;
        ri = k[8:0];
        rd_req = 1'b1;
        exp_q.push_back(e);
    endtask
    task automatic rd_end();
        @(negedge mclk);
        rd_req = 1'b0;
    endtask
    task automatic acq(input logic [1:0] m, input logic s, input logic [15:0] sc);
        @(negedge mclk);
        mode = m;
        slot = s;
        scale = sc;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
    endtask
    task automatic halt();
        @(negedge mclk);
        stop = 1'b1;
        @(negedge mclk);
        stop = 1'b0;
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 1500 && done !== 1'b1; k++) @(negedge mclk);
        check(done, 1'b1);
    endtask
    task automatic calc(input int k, input int v, input logic t, input logic l);
        @(negedge mclk);
        cv = 1'b1;
        cd = '{idx: k[8:0], val: v, tiny: t};
        cl = l;
        @(posedge mclk);
        while (cr !== 1'b1) @(posedge mclk);
        @(negedge mclk);
        cv = 1'b0;
        cd = ~cd;
        cl = 1'b0;
    endtask
    task automatic cst(input logic signed [12:0] e, input logic signed [12:0] eo, input logic st,
                       input logic z);
        @(negedge mclk);
        ci = '{sgn: 1'b1, ex: e, man: 16'h8000};
        @(negedge mclk);
        check(co.ex, eo);
        check(co.sgn, 1'b1);
        check({stars, zero}, {st, z});
    endtask
    task automatic xy_chk(input logic [15:0] sc);
        @(negedge mclk);
        xy = 1'b1;
        hs = 1'b1;
        cur = -16'sd7;
        @(negedge mclk);
        check(hsf, sc);
        check(hcr, -32'sd7 * signed'({16'h0000, sc}));
    endtask
    initial begin
        {start, stop, xy, cv, cl, rd_req, mode, slot, rs, hs, ri, scale, cur} = '0;
        cd = '0;
        ci = '0;
        void'($urandom(32'hF3DD));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        check({busy, sr, cr}, 3'h3);
        // Buffer fills while idle; gated-off pairs must be dropped once drained
        fork
            repeat (3) wa_front_inst.send(1'b0, 16'sd5, 16'hDEAD);
        join_none
        repeat (8) @(negedge mclk);
        check(sr, 1'b0);
        acq(wa_pkg::MODE_ET, 1'b0, 16'h0002);
        check(busy, 1'b1);
        wait fork;
        wa_front_inst.send(1'b1, -16'sd3, 16'h1234);
        wa_front_inst.send(1'b1, 16'sd10, 16'h4321);
        for (i = 0; i < 510; i++) begin
            ev[i] = 16'($urandom & 32'h1FFE);
            if (i != 100) wa_front_inst.send(1'b1, 16'(i), ev[i]);
        end
        wa_front_inst.send(1'b0, 16'sd20, 16'h3333);
        wa_front_inst.sweep();
        wait_done();
        for (i = 0; i < 512; i++)
            rd(1'b0, i, i == 0 ? ev[1] : i == 100 ? 16'((ev[99] + ev[101]) >> 1) : i > 509 ? ev[509] : ev[i]);
        rd_end();
        acq(wa_pkg::MODE_AVG, 1'b1, 16'h0005);
        halt();
        wait_done();
        for (i = 0; i < 512; i++) rd(1'b1, i, 16'h0000);
        rd_end();
        xy_chk(16'h0005);
        // Averaged mode: a repeated index keeps the mean of old and new
        acq(wa_pkg::MODE_AVG, 1'b0, 16'h0006);
        wa_front_inst.send(1'b1, 16'sd3, 16'h0100);
        wa_front_inst.send(1'b1, 16'sd3, 16'h0300);
        halt();
        wait_done();
        rd(1'b0, 3, 16'h0200);
        rd(1'b0, 511, 16'h0200);
        rd_end();
        acq(wa_pkg::MODE_RT, 1'b1, 16'h0003);
        for (i = 0; i < 520; i++) wa_front_inst.tick(16'(1000 + i));
        @(negedge mclk);
        check(rt_base, 9'h008);
        halt();
        wait_done();
        for (i = 0; i < 512; i++) rd(1'b1, i, 16'(1000 + (i < 8 ? i + 512 : i)));
        rd_end();
        xy_chk(16'h0003);
        calc(5, 40000, 1'b0, 1'b0);
        calc(6, -40000, 1'b0, 1'b0);
        calc(7, 123, 1'b0, 1'b1);
        rd(1'b0, 5, wa_pkg::PT_SAT_P);
        rd(1'b0, 7, 16'h007B);
        rd(1'b0, 6, wa_pkg::PT_SAT_N);
        rd_end();
        @(negedge mclk);
        @(negedge mclk);
        check(rdp, wa_pkg::DISP_N3);
        calc(0, 1, 1'b1, 1'b1);
        wait_done();
        rd(1'b0, 7, 16'h0000);
        rd_end();
        cst(13'sd2000, wa_pkg::EXP_MAX, 1'b1, 1'b0);
        cst(13'sd400, 13'sd400, 1'b1, 1'b0);
        cst(-13'sd400, -13'sd400, 1'b0, 1'b1);
        cst(13'sd10, 13'sd10, 1'b0, 1'b0);
        @(negedge mclk);
        ci = '{sgn: 1'b0, ex: -13'sd2000, man: 16'h8000};
        @(negedge mclk);
        check({zero, co.man}, 17'h10000);
        results();
    end
    // Whole run needs some six thousand cycles; this allows several times that
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
